// *** common/mfp_pkg.sv ***
// Package with register map, field layout and carrier types for the multifunction pin block.
// ============================================================================
// Notes on behaviour
// - Function 0000 powers down both pin buffers.
// - Function 0001 makes the pin an input.
// - Function 0010 makes the pin a general input.
// - Function 0011 drives the output value bit.
// - Function 0100 drives the divided clock output.
// - Codes 0101/0110 drive interrupt line a/b.
// - Codes 1000/1001 drive secondary bit/word clock.
// - Read-only bit shows general pin input level.
// - Output value bit, reset zero, sets level.
// - Data pin code 00 powers down its buffer.
// - Data pin code 01, reset value, enables it.
// - Data pin code 10 general input; 11 reserved.
// - Single-pulse interrupt is one pulse of about 2 ms.
package mfp_pkg;

  // ============================================================================
  // Register offsets
  localparam logic [7:0] MFP_REG_RSVD_A    = 8'h32;
  localparam logic [7:0] MFP_REG_GPIN_CTRL = 8'h33;
  localparam logic [7:0] MFP_REG_RSVD_B    = 8'h34;
  localparam logic [7:0] MFP_REG_RSVD_C    = 8'h35;
  localparam logic [7:0] MFP_REG_DIN_CTRL  = 8'h36;
  localparam logic [7:0] MFP_REG_RSVD_D    = 8'h37;
  localparam logic [7:0] MFP_REG_RSVD_E    = 8'h38;
  localparam logic [7:0] MFP_REG_RSVD_F    = 8'h39;
  localparam logic [7:0] MFP_REG_RSVD_G    = 8'h3A;
  localparam logic [7:0] MFP_REG_RSVD_H    = 8'h3B;

  // ============================================================================
  // Reset values
  localparam logic [7:0] MFP_RST_ZERO   = 8'h00;
  localparam logic [7:0] MFP_RST_RSVD_C = 8'h09;
  localparam logic [3:0] MFP_RST_GFUNC  = 4'h0;
  localparam logic [1:0] MFP_RST_DFUNC  = 2'h1;
  localparam logic [1:0] MFP_RST_GTOP   = 2'h0;
  localparam logic [4:0] MFP_RST_DTOP   = 5'h00;

  // ============================================================================
  // Field positions
  localparam int MFP_GTOP_HI  = 7;
  localparam int MFP_GTOP_LO  = 6;
  localparam int MFP_GFUNC_HI = 5;
  localparam int MFP_GFUNC_LO = 2;
  localparam int MFP_GIN_BIT  = 1;
  localparam int MFP_GOUT_BIT = 0;
  localparam int MFP_DTOP_HI  = 7;
  localparam int MFP_DTOP_LO  = 3;
  localparam int MFP_DFUNC_HI = 2;
  localparam int MFP_DFUNC_LO = 1;
  localparam int MFP_DIN_BIT  = 0;

  // ============================================================================
  // Function codes
  localparam logic [3:0] MFP_G_OFF     = 4'h0;
  localparam logic [3:0] MFP_G_INPUT   = 4'h1;
  localparam logic [3:0] MFP_G_GPI     = 4'h2;
  localparam logic [3:0] MFP_G_GPO     = 4'h3;
  localparam logic [3:0] MFP_G_DIVIDED_CLOCK_OUTPUT  = 4'h4;
  localparam logic [3:0] MFP_G_INT_A   = 4'h5;
  localparam logic [3:0] MFP_G_INT_B   = 4'h6;
  localparam logic [3:0] MFP_G_BCLK    = 4'h8;
  localparam logic [3:0] MFP_G_WCLK    = 4'h9;
  localparam logic [1:0] MFP_D_OFF     = 2'h0;
  localparam logic [1:0] MFP_D_SERIAL  = 2'h1;
  localparam logic [1:0] MFP_D_GPI     = 2'h2;

  // ============================================================================
  // Carrier types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mfp_req_t;

  typedef struct packed {
    logic divided_clock_output;
    logic interrupt_line_a;
    logic interrupt_line_b;
    logic sec_bit_clock;
    logic sec_word_clock;
  } mfp_src_t;

  typedef struct packed {
    logic gpin_out;
    logic gpin_oe_n;
    logic gpin_ibuf_en;
    logic din_ibuf_en;
    logic gpin_input_use;
    logic din_serial_use;
  } mfp_pin_t;

endpackage

// *** tb/mfp_pin_ctrl_bench.sv ***
// Self-checking bench for the multifunction pin control.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mfp_pin_ctrl_bench
  import mfp_pkg::*;
;
  logic       clk_in;
  logic       rst_n_in;
  mfp_req_t   req;
  mfp_src_t   src;
  logic [7:0] rdata;
  logic       rvalid;
  mfp_pin_t   pin;
  logic       glvl;
  logic       dlvl;
  logic       gwire;
  logic       dwire;
  logic       ext_en;
  logic       ext_lvl;
  int         fails;
  int         num_checks;
  mfp_pin_ctrl dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .src_in(src), .general_pin_one_in(gwire), .din_pin_in(dwire),
    .pin_out(pin), .general_pin_one_level_out(glvl), .din_level_out(dlvl));
  mfp_pin_partner far_u (.clk_in(clk_in), .pin_in(pin), .ext_en_in(ext_en),
    .ext_level_in(ext_lvl), .gpin_wire_out(gwire), .din_wire_out(dwire));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
  // ==========
  // Bus helpers: each call holds its request for exactly one edge.
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk_in);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    repeat (4) op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    logic [7:0] exp [10] = '{8'h00, 8'h00, 8'h00, 8'h09, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    `CHK("oe_n", 1'b1, pin.gpin_oe_n)
    `CHK("din_use", 1'b1, pin.din_serial_use)
    for (int i = 0; i < 10; i++) rd_chk(8'h32 + i[7:0], exp[i]);
  endtask
  task automatic t_gpin();
    logic [4:0] sel [16] = '{0, 0, 0, 0, 5'h10, 5'h08, 5'h04, 0, 5'h02, 5'h01, 0, 0, 0, 0, 0, 0};
    logic       drv;
    for (int c = 0; c < 16; c++) begin
      for (int v = 0; v < 2; v++) begin
        if (c == 7 || c > 9) continue;
        drv = c inside {3, 4, 5, 6, 8, 9};
        src = v ? sel[c] : ~sel[c];
        wr_reg(MFP_REG_GPIN_CTRL, {2'b00, c[3:0], 1'b0, v[0]});
        `CHK("oe_n", ~drv, pin.gpin_oe_n)
        if (drv) `CHK("gpin", v[0], pin.gpin_out)
        if (!drv) `CHK("ibuf", c == 1 || c == 2, pin.gpin_ibuf_en)
        `CHK("in_use", c == 1, pin.gpin_input_use)
        if (c < 3) `CHK("glvl", c != 0, glvl)
        if (c == 2) rd_chk(MFP_REG_GPIN_CTRL, {6'h02, 1'b1, v[0]});
      end
    end
  endtask
  task automatic t_din();
    for (int c = 0; c < 3; c++) begin
      wr_reg(MFP_REG_DIN_CTRL, {5'h00, c[1:0], 1'b0});
      `CHK("din_ibuf", c != 0, pin.din_ibuf_en)
      `CHK("din_use", c == 1, pin.din_serial_use)
      `CHK("dlvl", c != 0, dlvl)
      rd_chk(MFP_REG_DIN_CTRL, {5'h00, c[1:0], c != 0});
    end
  endtask
  task automatic t_rsvd();
    wr_reg(MFP_REG_RSVD_A, 8'h00);
    rd_chk(MFP_REG_RSVD_A, 8'h00);
    wr_reg(MFP_REG_RSVD_H, 8'h00);
    rd_chk(MFP_REG_RSVD_H, 8'h00);
    wr_reg(8'h5A, 8'hFF);
    rd_chk(8'h5A, 8'h00);
    wr_reg(MFP_REG_GPIN_CTRL, 8'h0D);
    `CHK("gpin", 1'b1, pin.gpin_out)
    op(1'b1, 1'b1, MFP_REG_GPIN_CTRL, 8'h0C);
    `CHK("old", 8'h0D, rdata & 8'hFD)
    repeat (2) op(1'b0, 1'b0, 8'h00, 8'h00);
    `CHK("gpin", 1'b0, pin.gpin_out)
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    fails = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    req = '0;
    src = '0;
    ext_en = 1'b1;
    ext_lvl = 1'b1;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_gpin();
    t_din();
    t_rsvd();
    finish_test();
  end
endmodule
bind mfp_pin_ctrl mfp_pin_ctrl_properties chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .src_in(src_in),
  .general_pin_one_in(general_pin_one_in), .din_pin_in(din_pin_in), .pin_out(pin_out),
  .general_pin_one_level_out(general_pin_one_level_out), .din_level_out(din_level_out));

// *** tb/mfp_pin_ctrl_properties.sv ***
// Port-level checks for the multifunction pin control.
`timescale 1ns/1ps
module mfp_pin_ctrl_properties
  import mfp_pkg::*;
(
  // Watched ports
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire mfp_req_t   req_in,
  input wire logic [7:0] rdata_out,
  input wire logic       rvalid_out,
  input wire mfp_src_t   src_in,
  input wire logic       general_pin_one_in,
  input wire logic       din_pin_in,
  input wire mfp_pin_t   pin_out,
  input wire logic       general_pin_one_level_out,
  input wire logic       din_level_out
);
  logic       gw;
  logic       dw;
  logic [3:0] gf;
  logic [1:0] df;
  mfp_pin_t   p;
  assign gw = req_in.wr && req_in.addr == MFP_REG_GPIN_CTRL;
  assign dw = req_in.wr && req_in.addr == MFP_REG_DIN_CTRL;
  assign gf = req_in.wdata[5:2];
  assign df = req_in.wdata[2:1];
  assign p = pin_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========
  // Pin effects land one edge after the write is taken; the checks look at the second edge.
  property p_off; gw && gf inside {0, 7, [10:15]} |->
    ##2 p.gpin_oe_n && !p.gpin_ibuf_en; endproperty
  a_off: assert property (p_off) else $error("idle code drives");
  property p_inp; gw && gf == 4'h1 |->
    ##2 p.gpin_input_use && p.gpin_ibuf_en && p.gpin_oe_n; endproperty
  a_inp: assert property (p_inp) else $error("input mode wrong");
  property p_gpi; gw && gf == 4'h2 |->
    ##2 !p.gpin_input_use && p.gpin_ibuf_en && p.gpin_oe_n; endproperty
  a_gpi: assert property (p_gpi) else $error("general input wrong");
  property p_gpo; gw && gf == 4'h3 |->
    ##2 !p.gpin_oe_n && p.gpin_out == $past(req_in.wdata[0], 2); endproperty
  a_gpo: assert property (p_gpo) else $error("output value wrong");
  property p_drv; gw && gf inside {4, 5, 6, 8, 9} |-> ##2 !p.gpin_oe_n; endproperty
  a_drv: assert property (p_drv) else $error("routed source undriven");
  property p_doff; dw && df == 2'h0 |-> ##2 !p.din_ibuf_en && !p.din_serial_use; endproperty
  a_doff: assert property (p_doff) else $error("data pin not off");
  property p_dser; dw && df == 2'h1 |-> ##2 p.din_ibuf_en && p.din_serial_use; endproperty
  a_dser: assert property (p_dser) else $error("data pin not serial");
  property p_dgpi; dw && df == 2'h2 |-> ##2 p.din_ibuf_en && !p.din_serial_use; endproperty
  a_dgpi: assert property (p_dgpi) else $error("data pin not input");
  property p_rv; 1 |=> rvalid_out == $past(req_in.rd); endproperty
  a_rv: assert property (p_rv) else $error("read answer late");
endmodule

// *** tb/mfp_pin_partner.sv ***
// Board wiring and external drivers on the two multifunction pins.
`timescale 1ns/1ps
module mfp_pin_partner
  import mfp_pkg::*;
(
  // Device side
  input  wire logic     clk_in,
  input  wire mfp_pin_t pin_in,
  // External driver
  input  wire logic     ext_en_in,
  input  wire logic     ext_level_in,
  // Resolved wires
  output      logic     gpin_wire_out,
  output      logic     din_wire_out
);
  logic flip;
  initial flip = 1'b0;
  always @(posedge clk_in) flip <= ~flip;
  // Neither line has a pull, so an undriven wire wanders; the toggle stands in for that.
  assign gpin_wire_out = !pin_in.gpin_oe_n ? pin_in.gpin_out : ext_en_in ? ext_level_in : flip;
  assign din_wire_out = ext_en_in ? ext_level_in : flip;
endmodule

// *** verilog/mfp_pin_ctrl.sv ***
// Multifunction pin control: register bank and pin muxing for the general pin and data pin.
`timescale 1ns/1ps
module mfp_pin_ctrl
  import mfp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Register port from the control interface decoder
  input  wire mfp_req_t   req_in,
  output      logic [7:0] rdata_out,
  output      logic       rvalid_out,
  // Internal signal sources routed to the general pin
  input  wire mfp_src_t   src_in,
  // Pins
  input  wire logic       general_pin_one_in,
  input  wire logic       din_pin_in,
  output      mfp_pin_t   pin_out,
  // Synchronised pin levels for the consumers
  output      logic       general_pin_one_level_out,
  output      logic       din_level_out
);

  // ============================================================================
  // State
  typedef struct packed {
    logic [1:0] gtop;
    logic [3:0] gfunc;
    logic       gout;
    logic [4:0] dtop;
    logic [1:0] dfunc;
    logic [7:0] rsvd_a;
    logic [7:0] rsvd_b;
    logic [7:0] rsvd_c;
    logic [7:0] rsvd_d;
    logic [7:0] rsvd_e;
    logic [7:0] rsvd_f;
    logic [7:0] rsvd_g;
    logic [7:0] rsvd_h;
    logic [1:0] gsync;
    logic [1:0] dsync;
    logic [7:0] rdata;
    logic       rvalid;
    mfp_pin_t   pin;
    logic       glevel;
    logic       dlevel;
  } mfp_state_t;

  mfp_state_t st;
  mfp_state_t next_st;

  // Decides whether the general pin drives; reserved codes leave it undriven.
  function automatic logic gfunc_drives(input logic [3:0] f);
    gfunc_drives = (f == MFP_G_GPO) || (f == MFP_G_DIVIDED_CLOCK_OUTPUT) || (f == MFP_G_INT_A) ||
                   (f == MFP_G_INT_B) || (f == MFP_G_BCLK) || (f == MFP_G_WCLK);
  endfunction

  // ============================================================================
  // Next state
  always_comb begin
    logic       g_in;
    logic       d_in;
    logic       gsrc;
    g_in           = 1'b0;
    d_in           = 1'b0;
    gsrc           = 1'b0;
    next_st        = st;
    next_st.rvalid = 1'b0;
    // The second stage is the only reader of the first.
    next_st.gsync  = {st.gsync[0], general_pin_one_in};
    next_st.dsync  = {st.dsync[0], din_pin_in};
    // An off function code reads as low; every other code passes the synchronised level.
    g_in = st.gsync[1] & (st.gfunc != MFP_G_OFF);
    d_in = st.dsync[1] & (st.dfunc != MFP_D_OFF);

    if (req_in.wr) begin
      if (req_in.addr == MFP_REG_RSVD_A) begin
        next_st.rsvd_a = req_in.wdata;
      end else if (req_in.addr == MFP_REG_GPIN_CTRL) begin
        next_st.gtop  = req_in.wdata[MFP_GTOP_HI:MFP_GTOP_LO];
        next_st.gfunc = req_in.wdata[MFP_GFUNC_HI:MFP_GFUNC_LO];
        next_st.gout  = req_in.wdata[MFP_GOUT_BIT];
      end else if (req_in.addr == MFP_REG_RSVD_B) begin
        next_st.rsvd_b = req_in.wdata;
      end else if (req_in.addr == MFP_REG_RSVD_C) begin
        next_st.rsvd_c = req_in.wdata;
      end else if (req_in.addr == MFP_REG_DIN_CTRL) begin
        next_st.dtop  = req_in.wdata[MFP_DTOP_HI:MFP_DTOP_LO];
        next_st.dfunc = req_in.wdata[MFP_DFUNC_HI:MFP_DFUNC_LO];
      end else if (req_in.addr == MFP_REG_RSVD_D) begin
        next_st.rsvd_d = req_in.wdata;
      end else if (req_in.addr == MFP_REG_RSVD_E) begin
        next_st.rsvd_e = req_in.wdata;
      end else if (req_in.addr == MFP_REG_RSVD_F) begin
        next_st.rsvd_f = req_in.wdata;
      end else if (req_in.addr == MFP_REG_RSVD_G) begin
        next_st.rsvd_g = req_in.wdata;
      end else if (req_in.addr == MFP_REG_RSVD_H) begin
        next_st.rsvd_h = req_in.wdata;
      end
    end

    if (req_in.rd) begin
      next_st.rvalid = 1'b1;
      if (req_in.addr == MFP_REG_RSVD_A) begin
        next_st.rdata = st.rsvd_a;
      end else if (req_in.addr == MFP_REG_GPIN_CTRL) begin
        next_st.rdata = {st.gtop, st.gfunc, g_in, st.gout};
      end else if (req_in.addr == MFP_REG_RSVD_B) begin
        next_st.rdata = st.rsvd_b;
      end else if (req_in.addr == MFP_REG_RSVD_C) begin
        next_st.rdata = st.rsvd_c;
      end else if (req_in.addr == MFP_REG_DIN_CTRL) begin
        next_st.rdata = {st.dtop, st.dfunc, d_in};
      end else if (req_in.addr == MFP_REG_RSVD_D) begin
        next_st.rdata = st.rsvd_d;
      end else if (req_in.addr == MFP_REG_RSVD_E) begin
        next_st.rdata = st.rsvd_e;
      end else if (req_in.addr == MFP_REG_RSVD_F) begin
        next_st.rdata = st.rsvd_f;
      end else if (req_in.addr == MFP_REG_RSVD_G) begin
        next_st.rdata = st.rsvd_g;
      end else if (req_in.addr == MFP_REG_RSVD_H) begin
        next_st.rdata = st.rsvd_h;
      end else begin
        next_st.rdata = MFP_RST_ZERO;
      end
    end

    // Pin routing follows the stored function, so a new code takes effect one cycle later.
    case (st.gfunc)
      MFP_G_GPO:    gsrc = st.gout;
      MFP_G_DIVIDED_CLOCK_OUTPUT: gsrc = src_in.divided_clock_output;
      MFP_G_INT_A:  gsrc = src_in.interrupt_line_a;
      MFP_G_INT_B:  gsrc = src_in.interrupt_line_b;
      MFP_G_BCLK:   gsrc = src_in.sec_bit_clock;
      MFP_G_WCLK:   gsrc = src_in.sec_word_clock;
      default:      gsrc = 1'b0;
    endcase
    next_st.pin.gpin_out       = gsrc;
    next_st.pin.gpin_oe_n      = ~gfunc_drives(st.gfunc);
    next_st.pin.gpin_ibuf_en   = (st.gfunc == MFP_G_INPUT) || (st.gfunc == MFP_G_GPI);
    next_st.pin.gpin_input_use = (st.gfunc == MFP_G_INPUT);
    next_st.pin.din_ibuf_en    = (st.dfunc == MFP_D_SERIAL) || (st.dfunc == MFP_D_GPI);
    next_st.pin.din_serial_use = (st.dfunc == MFP_D_SERIAL);
    next_st.glevel             = g_in;
    next_st.dlevel             = d_in;
  end

  // ============================================================================
  // Registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st        <= '0;
      st.gtop   <= MFP_RST_GTOP;
      st.gfunc  <= MFP_RST_GFUNC;
      st.gout   <= 1'b0;
      st.dtop   <= MFP_RST_DTOP;
      st.dfunc  <= MFP_RST_DFUNC;
      st.rsvd_a <= MFP_RST_ZERO;
      st.rsvd_c <= MFP_RST_RSVD_C;
      st.pin.gpin_oe_n      <= 1'b1;
      st.pin.din_ibuf_en    <= 1'b1;
      st.pin.din_serial_use <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out                 = st.rdata;
  assign rvalid_out                = st.rvalid;
  assign pin_out                   = st.pin;
  assign general_pin_one_level_out = st.glevel;
  assign din_level_out             = st.dlevel;

endmodule
